// ---- logic/dac_front_pkg.sv ----
// Constants, codes and register map of the stereo serial audio front end.
package dac_front_pkg;
   localparam int unsigned SAMPLE_W = 24;
   localparam int unsigned INIT_CYCLES = 3072;
   localparam int unsigned INIT_W = 12;
   localparam int unsigned ZERO_RUN = 1024;
   localparam int unsigned ZCNT_W = 11;
   localparam int unsigned BCK_LOSS_PERIODS = 3;
   localparam int unsigned WS_TOL = 4;
   localparam int unsigned BIT_IDX_W = 6;
   localparam int unsigned AXI_ADDR_W = 9;
   localparam int unsigned AXI_DATA_W = 32;

   // Register indices; the byte address is four times the index.
   localparam logic [6:0] IDX_FORMAT = 7'h14;
   localparam logic [6:0] IDX_FLAGCFG = 7'h16;
   localparam logic [6:0] IDX_CTRL = 7'h18;
   localparam logic [6:0] IDX_STATUS = 7'h19;

   localparam int unsigned FMT_LSB = 0;
   localparam int unsigned FMT_W = 3;
   localparam int unsigned FLAG_POLARITY_INVERT_BIT = 1;
   localparam int unsigned COMMON_FLAG_SELECT_BIT = 2;
   localparam int unsigned PIN_MODE_BIT = 0;
   localparam int unsigned ST_RUN_BIT = 0;
   localparam int unsigned ST_SUSP_BIT = 1;
   localparam int unsigned ST_OS_LSB = 2;
   localparam int unsigned ST_RATIO_LSB = 4;
   localparam int unsigned ST_ZL_BIT = 7;
   localparam int unsigned ST_ZR_BIT = 8;

   localparam logic [2:0] FMT_RJ24 = 3'h0;
   localparam logic [2:0] FMT_RJ20 = 3'h1;
   localparam logic [2:0] FMT_RJ18 = 3'h2;
   localparam logic [2:0] FMT_RJ16 = 3'h3;
   localparam logic [2:0] FMT_I2S = 3'h4;
   localparam logic [2:0] FMT_LJ = 3'h5;
   localparam logic [2:0] FMT_DEFAULT = FMT_LJ;
   localparam logic FLAG_POLARITY_INVERT_DEFAULT = 1'b0;
   localparam logic COMMON_FLAG_SELECT_DEFAULT = 1'b0;
   localparam logic PIN_MODE_DEFAULT = 1'b0;
   // Left shift that puts a right-justified word of 24, 20, 18 or 16 bits at the top.
   localparam logic [4:0] RJ_PAD [4] = '{5'h00, 5'h04, 5'h06, 5'h08};

   // Boundaries between the ratios 128, 192, 256, 384, 512, 768 and 1152.
   localparam int unsigned RATIO_STEPS = 6;
   localparam int unsigned RATIO_EDGE [6] = '{160, 224, 320, 448, 640, 960};
   localparam logic [2:0] RATIO_32X_MIN = 3'h2;
   localparam logic [2:0] RATIO_64X_MIN = 3'h4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {OS_16X, OS_32X, OS_64X} os_rate_t;
   typedef enum logic [2:0] {ST_OFF, ST_INIT, ST_ALIGN, ST_RUN, ST_SUSP} phase_t;
endpackage

// ---- logic/dac_front.sv ----
// Serial audio receiver, clock supervision and zero detection with an AXI4-Lite register port.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// R1 - Accept system clock 128 to 1152 fs
// R2 - Hold initialization 3072 clocks after power-good
// R3 - Load mode defaults when initialization ends
// R4 - Force mid-scale output during initialization
// R5 - Start within one sample period afterwards
// R6 - Shift data on bit clock rising edge
// R7 - Word select latches shifted word
// R8 - Host bit clock is 32/48/64 fs
// R9 - Host keeps serial clocks synchronous
// R10 - Processing follows word select at fs
// R11 - Suspend on rate change or clock loss
// R12 - Resynchronize alone within three sample periods
// R13 - Three-bit format field, left-justified default
// R14 - MSB first, two's-complement samples
// R15 - I2S low=left, left-justified high=left
// R16 - Oversampling chosen from detected ratio
// R17 - Zero after 1024 zero samples per channel
// R18 - Zero flag high for zero channel
// R19 - Polarity bit inverts flags, default high
// R20 - Common flag bit merges both channels
// R21 - Pin option: shared flag needs both
// R22 - Format pin: low I2S, high 16-bit RJ
// R23 - Nonzero sample clears zero run
module dac_front
   import dac_front_pkg::*;
#(
   parameter int unsigned CNT_W = 16
) (
   input wire logic I_CLK_SYS, // System clock.
   input wire logic I_RST, // Synchronous reset, active high.
   input wire logic I_POWER_GOOD, // Supply-good indication, asynchronous.
   input wire logic I_SERIAL_BIT_CLOCK, // Serial bit clock pin.
   input wire logic I_WORD_SELECT_CLOCK, // Word select clock pin.
   input wire logic I_SERIAL_DATA, // Serial audio data pin.
   input wire logic I_FORMAT_SELECT_PIN, // Format pin used in pin mode.
   input wire logic [AXI_ADDR_W-1:0] I_AXI_AWADDR, // Write address.
   input wire logic I_AXI_AWVALID, // Write address valid.
   output logic O_AXI_AWREADY, // Write address ready.
   input wire logic [AXI_DATA_W-1:0] I_AXI_WDATA, // Write data.
   input wire logic [3:0] I_AXI_WSTRB, // Write byte strobes.
   input wire logic I_AXI_WVALID, // Write data valid.
   output logic O_AXI_WREADY, // Write data ready.
   output logic [1:0] O_AXI_BRESP, // Write response.
   output logic O_AXI_BVALID, // Write response valid.
   input wire logic I_AXI_BREADY, // Write response ready.
   input wire logic [AXI_ADDR_W-1:0] I_AXI_ARADDR, // Read address.
   input wire logic I_AXI_ARVALID, // Read address valid.
   output logic O_AXI_ARREADY, // Read address ready.
   output logic [AXI_DATA_W-1:0] O_AXI_RDATA, // Read data.
   output logic [1:0] O_AXI_RRESP, // Read response.
   output logic O_AXI_RVALID, // Read data valid.
   input wire logic I_AXI_RREADY, // Read data ready.
   output logic O_LEFT_ZERO_FLAG, // Left zero flag pin.
   output logic O_RIGHT_ZERO_FLAG, // Right or shared zero flag pin.
   output logic [SAMPLE_W-1:0] O_LEFT_SAMPLE, // Left sample, MSB aligned.
   output logic [SAMPLE_W-1:0] O_RIGHT_SAMPLE, // Right sample, MSB aligned.
   output logic O_SAMPLE_STROBE, // Pulse when a right sample lands.
   output logic [1:0] O_OVERSAMPLE_RATE, // Chosen oversampling rate.
   output logic O_RUNNING // Normal operation.
);
   localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);
   localparam logic [ZCNT_W-1:0] ZERO_FULL = ZCNT_W'(ZERO_RUN);

   logic bck_m_r, bck_s_r, bck_d_r, ws_m_r, ws_s_r, dat_m_r, dat_s_r;
   logic fp_m_r, fp_s_r, pg_m_r, pg_s_r;
   logic ws_prev_r, per_ok_r, word_vld_r, word_left_r;
   logic [CNT_W-1:0] gap_cnt_r, bck_per_r, ws_cnt_r, ws_per_r, ws_diff;
   logic [CNT_W+1:0] loss_lim;
   logic [2:0] ratio_r, ratio_nxt;
   os_rate_t os_r;
   phase_t state_r;
   logic [INIT_W-1:0] init_cnt_r;
   logic [BIT_IDX_W-1:0] bit_idx_r;
   logic [SAMPLE_W-1:0] acc_r, rj_sh_r, word_r, word_nxt;
   logic [4:0] cap_r;
   logic [ZCNT_W-1:0] zcnt_r [2];
   logic [2:0] fmt_r, fmt_eff;
   logic flag_polarity_invert_r, common_flag_select_r, pin_mode_r;
   logic bck_rise, ws_edge, ws_rise, bck_lost, rate_change;
   logic is_i2s, is_rj, in_win, ch_left, zero_l, zero_r;
   logic aw_ready_r, w_ready_r, b_valid_r, ar_ready_r, r_valid_r;
   logic [1:0] b_resp_r, r_resp_r;
   logic [AXI_DATA_W-1:0] r_data_r, rd_word;
   logic rd_hit, wr_hit, wr_fire;
   logic left_flag_r, right_flag_r, run_r;
   logic [SAMPLE_W-1:0] left_r, right_r;
   logic strobe_r;

   // Two-stage synchronisers for every pin.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         {bck_m_r, bck_s_r, bck_d_r, ws_m_r, ws_s_r, dat_m_r, dat_s_r} <= 7'h00;
         {fp_m_r, fp_s_r, pg_m_r, pg_s_r} <= 4'h0;
      end else begin
         bck_m_r <= I_SERIAL_BIT_CLOCK;
         bck_s_r <= bck_m_r;
         bck_d_r <= bck_s_r;
         ws_m_r <= I_WORD_SELECT_CLOCK;
         ws_s_r <= ws_m_r;
         dat_m_r <= I_SERIAL_DATA;
         dat_s_r <= dat_m_r;
         fp_m_r <= I_FORMAT_SELECT_PIN;
         fp_s_r <= fp_m_r;
         pg_m_r <= I_POWER_GOOD;
         pg_s_r <= pg_m_r;
      end
   end

   assign bck_rise = bck_s_r & ~bck_d_r; // R6
   assign ws_edge = bck_rise && (ws_s_r != ws_prev_r); // R10
   assign ws_rise = ws_edge && ws_s_r;
   assign loss_lim = (CNT_W+2)'(bck_per_r) * (CNT_W+2)'(BCK_LOSS_PERIODS);
   assign bck_lost = (bck_per_r != '0) && ((CNT_W+2)'(gap_cnt_r) >= loss_lim); // R11 R8
   assign ws_diff = (ws_cnt_r > ws_per_r) ? ws_cnt_r - ws_per_r : ws_per_r - ws_cnt_r;
   assign rate_change = per_ok_r && (ws_diff > CNT_W'(WS_TOL)); // R11

   // Bit clock and word select period supervision.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         gap_cnt_r <= '0;
         bck_per_r <= '0;
         ws_cnt_r <= '0;
         ws_per_r <= '0;
         per_ok_r <= 1'b0;
      end else begin
         if (bck_rise) begin
            gap_cnt_r <= '0;
            bck_per_r <= gap_cnt_r + CNT_W'(1);
         end else if (gap_cnt_r != '1) begin
            gap_cnt_r <= gap_cnt_r + CNT_W'(1);
         end
         if (ws_rise) begin
            ws_cnt_r <= CNT_W'(1);
            ws_per_r <= ws_cnt_r;
            per_ok_r <= 1'b1;
         end else if (ws_cnt_r != '1) begin
            ws_cnt_r <= ws_cnt_r + CNT_W'(1);
         end
         if (bck_lost) begin
            per_ok_r <= 1'b0;
         end
      end
   end

   // Ratio of system clock to word select, from the last full period.
   always_comb begin
      ratio_nxt = 3'(RATIO_STEPS);
      for (int i = RATIO_STEPS - 1; i >= 0; i--) begin
         if (ws_cnt_r < CNT_W'(RATIO_EDGE[i])) begin
            ratio_nxt = 3'(i);
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         // A 512x code agrees with the 64x rate given out of reset.
         ratio_r <= RATIO_64X_MIN;
         os_r <= OS_64X;
      end else if (ws_rise && per_ok_r) begin
         ratio_r <= ratio_nxt; // R1
         if (ratio_nxt >= RATIO_64X_MIN) begin
            os_r <= OS_64X; // R16
         end else if (ratio_nxt >= RATIO_32X_MIN) begin
            os_r <= OS_32X; // R16
         end else begin
            os_r <= OS_16X; // R16
         end
      end
   end

   // Power-on initialization, alignment, running and suspension.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         state_r <= ST_OFF;
         init_cnt_r <= '0;
      end else if (!pg_s_r) begin
         state_r <= ST_OFF;
         init_cnt_r <= '0;
      end else begin
         unique case (state_r)
            ST_OFF: begin
               state_r <= ST_INIT; // R2
               init_cnt_r <= '0;
            end
            ST_INIT: begin
               if (init_cnt_r == INIT_LAST) begin
                  state_r <= ST_ALIGN; // R2
               end else begin
                  init_cnt_r <= init_cnt_r + INIT_W'(1); // R2
               end
            end
            ST_ALIGN: begin
               if (ws_edge) begin
                  state_r <= ST_RUN; // R5
               end
            end
            ST_RUN: begin
               if (bck_lost || (ws_rise && rate_change)) begin
                  state_r <= ST_SUSP; // R11
               end
            end
            ST_SUSP: begin
               if (ws_rise && per_ok_r && !rate_change && !bck_lost) begin
                  state_r <= ST_RUN; // R12
               end
            end
         endcase
      end
   end

   assign fmt_eff = pin_mode_r ? (fp_s_r ? FMT_RJ16 : FMT_I2S) : fmt_r; // R22 R13
   assign is_i2s = (fmt_eff == FMT_I2S);
   assign is_rj = (fmt_eff < FMT_I2S);
   assign in_win = (bit_idx_r >= BIT_IDX_W'(is_i2s))
      && (bit_idx_r < BIT_IDX_W'(SAMPLE_W) + BIT_IDX_W'(is_i2s));
   assign ch_left = is_i2s ? ~ws_prev_r : ws_prev_r; // R15
   // MSB-aligned two's-complement word; the sign stays in the top bit.
   assign word_nxt = is_rj ? (rj_sh_r << RJ_PAD[fmt_eff[1:0]]) // R14
      : (acc_r << (5'(SAMPLE_W) - cap_r));

   // Serial receiver: one bit per bit clock rising edge.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         ws_prev_r <= 1'b0;
         bit_idx_r <= '0;
         acc_r <= '0;
         cap_r <= '0;
         rj_sh_r <= '0;
         word_r <= '0;
         word_vld_r <= 1'b0;
         word_left_r <= 1'b0;
      end else begin
         word_vld_r <= 1'b0;
         if (bck_rise) begin
            ws_prev_r <= ws_s_r;
            if (ws_edge) begin
               word_r <= word_nxt; // R7
               word_vld_r <= 1'b1; // R7
               word_left_r <= ch_left;
               bit_idx_r <= BIT_IDX_W'(1);
               rj_sh_r <= SAMPLE_W'(dat_s_r); // R6
               acc_r <= is_i2s ? '0 : SAMPLE_W'(dat_s_r);
               cap_r <= is_i2s ? 5'h00 : 5'h01;
            end else begin
               rj_sh_r <= {rj_sh_r[SAMPLE_W-2:0], dat_s_r}; // R6
               if (bit_idx_r != '1) begin
                  bit_idx_r <= bit_idx_r + BIT_IDX_W'(1);
               end
               if (in_win) begin
                  acc_r <= {acc_r[SAMPLE_W-2:0], dat_s_r}; // R6
                  cap_r <= cap_r + 5'h01;
               end
            end
         end
      end
   end

   // Sample outputs sit at mid-scale (zero) whenever not running.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         left_r <= '0;
         right_r <= '0;
         strobe_r <= 1'b0;
         run_r <= 1'b0;
      end else begin
         run_r <= (state_r == ST_RUN);
         strobe_r <= 1'b0;
         if (state_r != ST_RUN) begin
            left_r <= '0; // R4
            right_r <= '0; // R4
         end else if (word_vld_r) begin
            if (word_left_r) begin
               left_r <= word_r;
            end else begin
               right_r <= word_r;
               strobe_r <= 1'b1;
            end
         end
      end
   end

   // Zero-run counters, index 0 left and 1 right.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         zcnt_r[0] <= '0;
         zcnt_r[1] <= '0;
      end else if (word_vld_r) begin
         if (word_r != '0) begin
            zcnt_r[word_left_r ? 0 : 1] <= '0; // R23
         end else if (zcnt_r[word_left_r ? 0 : 1] != ZERO_FULL) begin
            zcnt_r[word_left_r ? 0 : 1] <= zcnt_r[word_left_r ? 0 : 1] + ZCNT_W'(1); // R17
         end
      end
   end

   assign zero_l = (zcnt_r[0] == ZERO_FULL); // R17
   assign zero_r = (zcnt_r[1] == ZERO_FULL); // R17

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         left_flag_r <= 1'b0;
         right_flag_r <= 1'b0;
      end else if (pin_mode_r) begin
         left_flag_r <= 1'b0;
         right_flag_r <= zero_l & zero_r; // R21
      end else if (common_flag_select_r) begin
         left_flag_r <= flag_polarity_invert_r;
         right_flag_r <= (zero_l & zero_r) ^ flag_polarity_invert_r; // R20 R19
      end else begin
         left_flag_r <= zero_l ^ flag_polarity_invert_r; // R18 R19
         right_flag_r <= zero_r ^ flag_polarity_invert_r; // R18 R19
      end
   end

   // AXI4-Lite slave: address and data are taken together, response follows.
   assign wr_fire = aw_ready_r && I_AXI_AWVALID && w_ready_r && I_AXI_WVALID;
   assign wr_hit = (I_AXI_AWADDR[AXI_ADDR_W-1:2] == IDX_FORMAT)
      || (I_AXI_AWADDR[AXI_ADDR_W-1:2] == IDX_FLAGCFG)
      || (I_AXI_AWADDR[AXI_ADDR_W-1:2] == IDX_CTRL);

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         aw_ready_r <= 1'b0;
         w_ready_r <= 1'b0;
         b_valid_r <= 1'b0;
         b_resp_r <= RESP_OKAY;
      end else begin
         aw_ready_r <= 1'b0;
         w_ready_r <= 1'b0;
         if (b_valid_r && I_AXI_BREADY) begin
            b_valid_r <= 1'b0;
         end
         if (wr_fire) begin
            b_valid_r <= 1'b1;
            b_resp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (I_AXI_AWVALID && I_AXI_WVALID && !aw_ready_r && !b_valid_r) begin
            aw_ready_r <= 1'b1;
            w_ready_r <= 1'b1;
         end
      end
   end

   // Mode settings return to their defaults all through initialization.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || state_r == ST_INIT) begin
         fmt_r <= FMT_DEFAULT; // R3 R13
         flag_polarity_invert_r <= FLAG_POLARITY_INVERT_DEFAULT; // R3 R19
         common_flag_select_r <= COMMON_FLAG_SELECT_DEFAULT; // R3 R20
         pin_mode_r <= PIN_MODE_DEFAULT; // R3
      end else if (wr_fire && I_AXI_WSTRB[0]) begin
         if (I_AXI_AWADDR[AXI_ADDR_W-1:2] == IDX_FORMAT) begin
            fmt_r <= I_AXI_WDATA[FMT_LSB +: FMT_W]; // R13
         end
         if (I_AXI_AWADDR[AXI_ADDR_W-1:2] == IDX_FLAGCFG) begin
            flag_polarity_invert_r <= I_AXI_WDATA[FLAG_POLARITY_INVERT_BIT]; // R19
            common_flag_select_r <= I_AXI_WDATA[COMMON_FLAG_SELECT_BIT]; // R20
         end
         if (I_AXI_AWADDR[AXI_ADDR_W-1:2] == IDX_CTRL) begin
            pin_mode_r <= I_AXI_WDATA[PIN_MODE_BIT];
         end
      end
   end

   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      unique case (I_AXI_ARADDR[AXI_ADDR_W-1:2])
         IDX_FORMAT: rd_word[FMT_LSB +: FMT_W] = fmt_r;
         IDX_FLAGCFG: begin
            rd_word[FLAG_POLARITY_INVERT_BIT] = flag_polarity_invert_r;
            rd_word[COMMON_FLAG_SELECT_BIT] = common_flag_select_r;
         end
         IDX_CTRL: rd_word[PIN_MODE_BIT] = pin_mode_r;
         IDX_STATUS: begin
            rd_word[ST_RUN_BIT] = (state_r == ST_RUN);
            rd_word[ST_SUSP_BIT] = (state_r == ST_SUSP);
            rd_word[ST_OS_LSB +: 2] = os_r;
            rd_word[ST_RATIO_LSB +: 3] = ratio_r;
            rd_word[ST_ZL_BIT] = zero_l;
            rd_word[ST_ZR_BIT] = zero_r;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         ar_ready_r <= 1'b0;
         r_valid_r <= 1'b0;
         r_data_r <= '0;
         r_resp_r <= RESP_OKAY;
      end else begin
         ar_ready_r <= 1'b0;
         if (r_valid_r && I_AXI_RREADY) begin
            r_valid_r <= 1'b0;
         end
         if (ar_ready_r && I_AXI_ARVALID) begin
            r_valid_r <= 1'b1;
            r_data_r <= rd_word;
            r_resp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (I_AXI_ARVALID && !ar_ready_r && !r_valid_r) begin
            ar_ready_r <= 1'b1;
         end
      end
   end

   assign O_AXI_AWREADY = aw_ready_r;
   assign O_AXI_WREADY = w_ready_r;
   assign O_AXI_BVALID = b_valid_r;
   assign O_AXI_BRESP = b_resp_r;
   assign O_AXI_ARREADY = ar_ready_r;
   assign O_AXI_RVALID = r_valid_r;
   assign O_AXI_RDATA = r_data_r;
   assign O_AXI_RRESP = r_resp_r;
   assign O_LEFT_ZERO_FLAG = left_flag_r;
   assign O_RIGHT_ZERO_FLAG = right_flag_r;
   assign O_LEFT_SAMPLE = left_r;
   assign O_RIGHT_SAMPLE = right_r;
   assign O_SAMPLE_STROBE = strobe_r;
   assign O_OVERSAMPLE_RATE = os_r;
   assign O_RUNNING = run_r;

   default clocking dc @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);

   sequence s_init_step;
      state_r == ST_INIT && pg_s_r && init_cnt_r != INIT_LAST;
   endsequence
   sequence s_init_last;
      state_r == ST_INIT && pg_s_r && init_cnt_r == INIT_LAST;
   endsequence

   a_init_count: assert property (s_init_step |=> state_r == ST_INIT // R2
      && init_cnt_r == $past(init_cnt_r) + INIT_W'(1))
      else $error("initialization count did not advance");
   a_init_end: assert property (s_init_last |=> state_r == ST_ALIGN) // R2
      else $error("initialization did not end at its last count");
   a_defaults_load: assert property (state_r == ST_INIT |=> fmt_r == FMT_DEFAULT // R3
      && flag_polarity_invert_r == FLAG_POLARITY_INVERT_DEFAULT && common_flag_select_r == COMMON_FLAG_SELECT_DEFAULT)
      else $error("mode defaults not loaded during initialization");
   a_midscale_hold: assert property (state_r != ST_RUN |=> O_LEFT_SAMPLE == '0 // R4
      && O_RIGHT_SAMPLE == '0)
      else $error("outputs not at mid-scale while not running");
   a_align_start: assert property (state_r == ST_ALIGN && pg_s_r && ws_edge // R5
      |=> state_r == ST_RUN ##1 O_RUNNING)
      else $error("no start at first word select edge");
   a_bit_shift: assert property (bck_rise |=> rj_sh_r[0] == $past(dat_s_r)) // R6
      else $error("data bit not shifted on bit clock rise");
   a_word_latch: assert property (ws_edge |=> word_vld_r ##1 !word_vld_r) // R7
      else $error("word not latched on word select edge");
   a_clock_loss: assert property (state_r == ST_RUN && pg_s_r // R11
      && (bck_lost || (ws_rise && rate_change)) |=> state_r == ST_SUSP)
      else $error("no suspension on clock disturbance");
   a_resync_run: assert property (state_r == ST_SUSP && pg_s_r && ws_rise && per_ok_r // R12
      && !rate_change && !bck_lost |=> state_r == ST_RUN)
      else $error("no resynchronization after steady period");
   a_os_select: assert property (os_r == ((ratio_r >= RATIO_64X_MIN) ? OS_64X // R16
      : (ratio_r >= RATIO_32X_MIN) ? OS_32X : OS_16X))
      else $error("oversampling rate disagrees with ratio");
   a_zero_set: assert property (word_vld_r && word_left_r && word_r == '0 // R17
      && zcnt_r[0] == ZERO_FULL - ZCNT_W'(1) |=> zero_l ##1
      (pin_mode_r || common_flag_select_r || O_LEFT_ZERO_FLAG != flag_polarity_invert_r))
      else $error("left zero flag not raised after zero run");
   a_zero_clear: assert property (word_vld_r && word_left_r && word_r != '0 // R23
      |=> zcnt_r[0] == '0)
      else $error("nonzero sample did not clear zero run");
   a_flag_polar: assert property (!pin_mode_r && !common_flag_select_r // R19
      |=> O_LEFT_ZERO_FLAG == ($past(zero_l) ^ $past(flag_polarity_invert_r)))
      else $error("zero flag polarity wrong");
   a_flag_shared: assert property (pin_mode_r || common_flag_select_r |=> O_RIGHT_ZERO_FLAG // R20
      == (($past(zero_l) & $past(zero_r)) ^ ($past(flag_polarity_invert_r) & !$past(pin_mode_r))))
      else $error("shared zero flag wrong");
endmodule

// ---- sim/audio_host_model.sv ----
// Audio host model that drives the serial bit clock, word select and data.
`timescale 1ns/1ps
module audio_host_model (
   input wire logic i_en, // Send frames.
   input wire logic [1:0] i_mode, // 0 left-justified, 1 I2S, 2 right-justified.
   input wire logic [4:0] i_len, // Right-justified word length.
   input wire logic [23:0] i_left, // Left word.
   input wire logic [23:0] i_right, // Right word.
   output logic o_bck = 1'h0, // Bit clock.
   output logic o_ws = 1'h0, // Word select.
   output logic o_data = 1'h0 // Serial data.
);
   logic [23:0] w;
   int p;
   // The bit clock stands still while i_en is low, and the data line keeps toggling.
   always begin
      if (!i_en) begin
         #62.5 o_data = !o_data;
      end else begin
         for (int h = 0; h < 2; h++) begin
            w = h ? i_right : i_left;
            for (int b = 0; b < 32; b++) begin
               o_bck = 1'h0;
               o_ws = (i_mode == 2'h1) ? h[0] : !h[0];
               p = (i_mode == 2'h2) ? 31 - b : 23 - b + i_mode;
               o_data = (p >= 0 && p < ((i_mode == 2'h2) ? i_len : 24)) ? w[p] : b[0];
               #62.5 o_bck = 1'h1;
               #62.5;
            end
         end
      end
   end
endmodule

// ---- sim/stereo_dac_audio_input_and_zero_detect_tb.sv ----
// Self-checking bench for the serial audio front end.
`timescale 1ns/1ps
module stereo_dac_audio_input_and_zero_detect_tb
   import dac_front_pkg::*;
;
   typedef struct {logic [2:0] f; logic [1:0] m; logic [4:0] n; logic p; logic pin;
      logic [23:0] l; logic [23:0] r;} row_t;
   row_t rows [8] = '{
      '{FMT_LJ, 2'h0, 5'h18, 1'h0, 1'h0, 24'h800000, 24'h7fffff},
      '{FMT_I2S, 2'h1, 5'h18, 1'h0, 1'h0, 24'h123456, 24'hfedcba},
      '{FMT_RJ24, 2'h2, 5'h18, 1'h0, 1'h0, 24'h800001, 24'h7ffffe},
      '{FMT_RJ20, 2'h2, 5'h14, 1'h0, 1'h0, 24'h080001, 24'h07fffe},
      '{FMT_RJ18, 2'h2, 5'h12, 1'h0, 1'h0, 24'h020003, 24'h01fffc},
      '{FMT_RJ16, 2'h2, 5'h10, 1'h0, 1'h0, 24'h008001, 24'h007ffe},
      '{FMT_LJ, 2'h1, 5'h18, 1'h1, 1'h0, 24'h000001, 24'hffffff},
      '{FMT_LJ, 2'h2, 5'h10, 1'h1, 1'h1, 24'h001234, 24'h00edcb}};
   localparam logic [8:0] A_FMT = {IDX_FORMAT, 2'h0};
   localparam logic [8:0] A_FLAG = {IDX_FLAGCFG, 2'h0};
   localparam logic [8:0] A_CTRL = {IDX_CTRL, 2'h0};
   localparam logic [8:0] A_STAT = {IDX_STATUS, 2'h0};
   logic clk = 1'h0, rst = 1'h1, pg = 1'h0, fpin = 1'h0, en = 1'h1;
   logic [1:0] mode = 2'h0, bresp, rresp, rsp, os;
   logic [4:0] len = 5'h18;
   logic [23:0] left = 24'h0, right = 24'h0, lsmp, rsmp;
   logic [8:0] awaddr = 9'h0, araddr = 9'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, zl, zr, stb, run, serial_bit_clock, ws, sd;
   int err_count = 0, samples_checked = 0, cyc = 0, t0 = 0, sh;
   always #5 clk = !clk;
   always @(posedge clk) cyc <= cyc + 1;
   audio_host_model audio_host_model_inst (.i_en(en), .i_mode(mode), .i_len(len),
      .i_left(left), .i_right(right), .o_bck(serial_bit_clock), .o_ws(ws), .o_data(sd));
   dac_front dac_front_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_POWER_GOOD(pg),
      .I_SERIAL_BIT_CLOCK(serial_bit_clock), .I_WORD_SELECT_CLOCK(ws), .I_SERIAL_DATA(sd),
      .I_FORMAT_SELECT_PIN(fpin), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
      .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb),
      .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
      .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr),
      .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata),
      .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
      .O_LEFT_ZERO_FLAG(zl), .O_RIGHT_ZERO_FLAG(zr), .O_LEFT_SAMPLE(lsmp),
      .O_RIGHT_SAMPLE(rsmp), .O_SAMPLE_STROBE(stb), .O_OVERSAMPLE_RATE(os), .O_RUNNING(run));
   task automatic chk(input string n, input logic [47:0] g, input logic [47:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic axw(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (awvalid || wvalid);
      while (!bvalid) @(posedge clk);
      rsp = bresp;
      bready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rchk(input string n, input logic [8:0] a, input logic [31:0] e,
      input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clk); while (!rvalid);
      chk(n, {rdata, 14'h0, rresp}, {e, 14'h0, er});
      rready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wstb(input int k);
      repeat (k) begin
         do @(posedge clk); while (!stb);
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic print_verdict();
      if (err_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      left <= 24'h5a5a5a;
      @(posedge clk);
      pg <= 1'h1;
      t0 = cyc;
      repeat (100) @(posedge clk);
      axw(A_FMT, 32'(FMT_I2S), 4'hf);
      while (cyc - t0 < 3070) @(posedge clk);
      chk("init", 48'({run, lsmp}), 48'h0);
      while (!run && cyc - t0 < 4000) @(posedge clk);
      chk("running", 48'(run), 48'h1);
      wstb(2);
      rchk("format", A_FMT, 32'(FMT_LJ), RESP_OKAY);
      rchk("flagcfg", A_FLAG, 32'h0, RESP_OKAY);
      rchk("ctrl", A_CTRL, 32'h0, RESP_OKAY);
      rchk("unmapped", 9'h1fc, 32'h0, RESP_SLVERR);
      rchk("status", A_STAT, 32'h59, RESP_OKAY);
      chk("os rate", 48'(os), 48'(OS_64X));
      axw(A_STAT, 32'h0, 4'hf);
      chk("status write", 48'(rsp), 48'(RESP_SLVERR));
      foreach (rows[i]) begin
         axw(A_FMT, 32'(rows[i].f), 4'hf);
         axw(A_CTRL, 32'(rows[i].p), 4'hf);
         mode <= rows[i].m;
         len <= rows[i].n;
         fpin <= rows[i].pin;
         left <= rows[i].l;
         right <= rows[i].r;
         sh = (rows[i].m == 2'h2) ? 24 - rows[i].n : 0;
         wstb(4);
         chk("samples", {lsmp, rsmp}, {rows[i].l << sh, rows[i].r << sh});
      end
      axw(A_FLAG, 32'h2, 4'hf);
      chk("pin flags", 48'({zl, zr}), 48'h0);
      mode <= 2'h0;
      axw(A_CTRL, 32'h0, 4'hf);
      axw(A_FMT, 32'(FMT_I2S), 4'h0);
      rchk("format kept", A_FMT, 32'(FMT_LJ), RESP_OKAY);
      axw(A_FLAG, 32'h2, 4'hf);
      wstb(1);
      chk("flags inverted", 48'({zl, zr}), 48'h3);
      axw(A_FLAG, 32'h0, 4'hf);
      wstb(1);
      chk("flags", 48'({zl, zr}), 48'h0);
      en <= 1'h0;
      repeat (1000) @(posedge clk);
      chk("suspended", 48'(run), 48'h0);
      en <= 1'h1;
      t0 = cyc;
      while (!run && cyc - t0 < 2400) @(posedge clk);
      chk("resumed", 48'(run), 48'h1);
      wstb(2);
      chk("resumed data", 48'(lsmp), 48'h001234);
      print_verdict();
   end
   initial begin
      #800000;
      err_count++;
      print_verdict();
   end
endmodule
